// ### logic/parallel_output_width_crossbar.sv
/*
  Parallel video output stage: width selection of received serial words, per-output crossbar,
  two-entry output buffer and APB register file.
  Assumes the serial word and its sync bits are stable around each rising edge of link_clk,
  which is much slower than pclk and is sampled as an ordinary input.
*/
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "xbar_regs.svh"

module parallel_output_width_crossbar (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic [28:0] serial_bits,
  input wire logic h_lo,
  input wire logic v_lo,
  input wire logic de_lo,
  input wire logic h_hi,
  input wire logic v_hi,
  input wire logic de_hi,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [13:0] dout,
  output logic horizontal_sync,
  output logic vertical_sync,
  output logic data_valid_flag
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int IN_W = 36;
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [IN_W-1:0] sync3_reg;
  logic link_lvl_reg;
  logic link_lvl_next;
  logic link_rise;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [31:0] xbar_lo_reg;
  logic [31:0] xbar_lo_next;
  logic [23:0] xbar_hi_reg;
  logic [23:0] xbar_hi_next;
  logic ovf_reg;
  logic ovf_next;
  logic [`PERIOD_W-1:0] period_cnt_reg;
  logic [`PERIOD_W-1:0] period_cnt_next;
  logic [`PERIOD_W-1:0] period_reg;
  logic [`PERIOD_W-1:0] period_next;
  xbar_pkg::push_state_e state_reg;
  xbar_pkg::push_state_e state_next;
  xbar_pkg::out_word_t word_a_reg;
  xbar_pkg::out_word_t word_a_next;
  xbar_pkg::out_word_t word_b_reg;
  xbar_pkg::out_word_t word_b_next;
  logic double_hold_reg;
  logic double_hold_next;
  logic [1:0] sync_source_select;
  logic [13:0] map_a;
  logic [13:0] map_b;
  logic [55:0] xbar_sel;
  logic buf_in_valid;
  logic buf_in_ready;
  xbar_pkg::out_word_t buf_in_data;
  xbar_pkg::out_word_t buf_out_data;
  logic wr_en;
  logic rd_en;
  logic ovf_clear;

  // ****************************************
  // Functions
  // ****************************************
  // One crossbar output from a 4-bit selection field
  function automatic logic xbar_pick(input logic [13:0] ins, input logic [3:0] sel);
    logic r;
    r = 1'b0;
    if (sel == `XBAR_FORCE_HIGH) begin
      r = 1'b1;
    end else if (sel == `XBAR_FORCE_LOW) begin
      r = 1'b0;
    end else if (sel < 4'(`XBAR_OUTPUTS)) begin
      r = ins[sel];
    end else begin
      r = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [13:0] xbar_map(input logic [13:0] ins, input logic [55:0] sels);
    logic [13:0] r;
    r = '0;
    for (int i = 0; i < `XBAR_OUTPUTS; i++) begin
      r[i] = xbar_pick(ins, sels[i*`XBAR_FIELD_W +: `XBAR_FIELD_W]);
    end
    return r;
  endfunction

  // ****************************************
  // Link input sampling
  // ****************************************
  // Link clock and data are asynchronous to pclk; the second and third stages feed the agreement check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= {link_clk, de_hi, v_hi, h_hi, de_lo, v_lo, h_lo, serial_bits};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_comb begin
    link_lvl_next = link_lvl_reg;
    if (sync2_reg[IN_W-1] == sync3_reg[IN_W-1]) begin
      link_lvl_next = sync3_reg[IN_W-1];
    end
  end
  assign link_rise = link_lvl_next && !link_lvl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_lvl_reg <= 1'b0;
    end else begin
      link_lvl_reg <= link_lvl_next;
    end
  end

  // ****************************************
  // Width selection
  // ****************************************
  always_comb begin
    // Sync source follows the width, bandwidth and encoding settings
    if (cfg_reg[`CFG_HIBAND_BIT] && !cfg_reg[`CFG_WIDE_BIT]) begin
      sync_source_select = 2'd0;
    end else if (cfg_reg[`CFG_DOUBLE_BIT] && !cfg_reg[`CFG_SYNCENC_BIT]) begin
      sync_source_select = 2'd3;
    end else begin
      sync_source_select = cfg_reg[`CFG_COMPAT_BIT] ? 2'd2 : 2'd1;
    end
  end

  // Mapping table covers the bus width, error check and double mode cases
  word_mapper u_mapper (
    .serial_bits(sync3_reg[28:0]),
    .h_lo(sync3_reg[29]),
    .v_lo(sync3_reg[30]),
    .de_lo(sync3_reg[31]),
    .h_hi(sync3_reg[32]),
    .v_hi(sync3_reg[33]),
    .de_hi(sync3_reg[34]),
    .bus_width_select(cfg_reg[`CFG_WIDE_BIT]),
    .double_word_mode(cfg_reg[`CFG_DOUBLE_BIT]),
    .high_bandwidth_mode(cfg_reg[`CFG_HIBAND_BIT]),
    .pixel_error_check(cfg_reg[`CFG_CRC_BIT]),
    .sync_encoding_enable(cfg_reg[`CFG_SYNCENC_BIT]),
    .data_enable_encoding(cfg_reg[`CFG_DEENC_BIT]),
    .sync_source_select(sync_source_select),
    .word_a(map_a),
    .word_b(map_b)
  );

  assign xbar_sel = {xbar_hi_reg, xbar_lo_reg};

  // ****************************************
  // Word sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    word_a_next = word_a_reg;
    word_b_next = word_b_reg;
    double_hold_next = double_hold_reg;
    buf_in_valid = 1'b0;
    buf_in_data = word_a_reg;
    case (state_reg)
      xbar_pkg::ST_IDLE: begin
        if (link_rise) begin
          // Crossbar applied at capture; sync fields pass straight through
          word_a_next = {sync3_reg[31], sync3_reg[30], sync3_reg[29], xbar_map(map_a, xbar_sel)};
          word_b_next = {sync3_reg[34], sync3_reg[33], sync3_reg[32], xbar_map(map_b, xbar_sel)};
          double_hold_next = cfg_reg[`CFG_DOUBLE_BIT];
          state_next = xbar_pkg::ST_FIRST;
        end
      end
      xbar_pkg::ST_FIRST: begin
        buf_in_valid = 1'b1;
        buf_in_data = word_a_reg;
        if (buf_in_ready) begin
          state_next = double_hold_reg ? xbar_pkg::ST_SECOND : xbar_pkg::ST_IDLE;
        end
      end
      xbar_pkg::ST_SECOND: begin
        buf_in_valid = 1'b1;
        buf_in_data = word_b_reg;
        if (buf_in_ready) begin
          state_next = xbar_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = xbar_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= xbar_pkg::ST_IDLE;
      word_a_reg <= '0;
      word_b_reg <= '0;
      double_hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      word_a_reg <= word_a_next;
      word_b_reg <= word_b_next;
      double_hold_reg <= double_hold_next;
    end
  end

  // ****************************************
  // Output buffer
  // ****************************************
  // A stalled sink fills the buffer and holds the sequencer; a link word arriving meanwhile is lost
  pair_buffer u_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(buf_out_data)
  );

  assign dout = buf_out_data[13:0];
  assign horizontal_sync = buf_out_data[14];
  assign vertical_sync = buf_out_data[15];
  assign data_valid_flag = buf_out_data[16];

  // ****************************************
  // Register file
  // ****************************************
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign ovf_clear = wr_en && paddr == `STATUS_ADDR && pwdata[`STAT_OVF_BIT];

  always_comb begin
    cfg_next = cfg_reg;
    xbar_lo_next = xbar_lo_reg;
    xbar_hi_next = xbar_hi_reg;
    ovf_next = ovf_reg;
    period_cnt_next = period_cnt_reg;
    period_next = period_reg;
    if (wr_en && paddr == `CFG_ADDR) begin
      // Low-rate bit is stored only; choosing it for a legacy partner is software's task
      cfg_next = pwdata[7:0];
    end
    if (wr_en && paddr == `XBAR_LO_ADDR) begin
      xbar_lo_next = pwdata;
    end
    if (wr_en && paddr == `XBAR_HI_ADDR) begin
      xbar_hi_next = pwdata[23:0];
    end
    if (ovf_clear) begin
      ovf_next = 1'b0;
    end
    // A new word before the previous one left is lost; set wins over clear
    if (link_rise && state_reg != xbar_pkg::ST_IDLE) begin
      ovf_next = 1'b1;
    end
    // Link period in pclk cycles, less one, lets software check the pixel clock range
    if (link_rise) begin
      period_next = period_cnt_reg;
      period_cnt_next = '0;
    end else if (period_cnt_reg != `PERIOD_MAX) begin
      period_cnt_next = period_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CFG_RESET;
      xbar_lo_reg <= `XBAR_LO_RESET;
      xbar_hi_reg <= `XBAR_HI_RESET;
      ovf_reg <= 1'b0;
      period_cnt_reg <= '0;
      period_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      xbar_lo_reg <= xbar_lo_next;
      xbar_hi_reg <= xbar_hi_next;
      ovf_reg <= ovf_next;
      period_cnt_reg <= period_cnt_next;
      period_reg <= period_next;
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        `CFG_ADDR: prdata = {24'h000000, cfg_reg};
        `XBAR_LO_ADDR: prdata = xbar_lo_reg;
        `XBAR_HI_ADDR: prdata = {8'h00, xbar_hi_reg};
        `STATUS_ADDR: prdata = {16'h0000, period_reg, 5'h00, ovf_reg, sync_source_select};
        default: pslverr = 1'b1;
      endcase
    end
    if (!rd_en) begin
      prdata = 32'h00000000;
    end
  end

endmodule

// ### logic/xbar_regs.svh
/*
  Register offsets, field positions, reset values and counts of the parallel output stage.
  Assumes inclusion from design and testbench files; holds definitions and nothing else.
*/
`ifndef XBAR_REGS_SVH
`define XBAR_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define CFG_ADDR 12'h000
`define XBAR_LO_ADDR 12'h004
`define XBAR_HI_ADDR 12'h008
`define STATUS_ADDR 12'h00c

// ****************************************
// Configuration fields
// ****************************************
`define CFG_WIDE_BIT 0
`define CFG_DOUBLE_BIT 1
`define CFG_HIBAND_BIT 2
`define CFG_CRC_BIT 3
`define CFG_SYNCENC_BIT 4
`define CFG_DEENC_BIT 5
`define CFG_LOWRATE_BIT 6
`define CFG_COMPAT_BIT 7
`define CFG_RESET 8'h00

// ****************************************
// Crossbar fields and codes
// ****************************************
`define XBAR_FIELD_W 4
`define XBAR_OUTPUTS 14
`define XBAR_LO_RESET 32'h76543210
`define XBAR_HI_RESET 24'hdcba98
`define XBAR_FORCE_LOW 4'he
`define XBAR_FORCE_HIGH 4'hf

// ****************************************
// Status fields
// ****************************************
`define STAT_SRC_LSB 0
`define STAT_OVF_BIT 2
`define STAT_PERIOD_LSB 8
`define PERIOD_W 8
`define PERIOD_MAX 8'hff

`endif

// ### logic/xbar_pkg.sv
/*
  Types shared by the parallel output stage.
  Assumes the constants of xbar_regs.svh beside it.
*/
package xbar_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } push_state_e;

  // {data_valid_flag, vertical_sync, horizontal_sync, dout[13:0]}
  typedef logic [16:0] out_word_t;

endpackage

// ### logic/word_mapper.sv
/*
  Maps one received serial word onto the first and second output words.
  Assumes stable inputs from the caller's clock domain; purely combinational.
*/
`timescale 1ns/1ns
module word_mapper (
  input wire logic [28:0] serial_bits,
  input wire logic h_lo,
  input wire logic v_lo,
  input wire logic de_lo,
  input wire logic h_hi,
  input wire logic v_hi,
  input wire logic de_hi,
  input wire logic bus_width_select,
  input wire logic double_word_mode,
  input wire logic high_bandwidth_mode,
  input wire logic pixel_error_check,
  input wire logic sync_encoding_enable,
  input wire logic data_enable_encoding,
  input wire logic [1:0] sync_source_select,
  output logic [13:0] word_a,
  output logic [13:0] word_b
);
  int n;
  int off;

  always_comb begin
    word_a = '0;
    word_b = '0;
    n = 11;
    off = 11;
    if (!double_word_mode) begin
      for (int i = 0; i < 11; i++) begin
        word_a[i] = serial_bits[i];
      end
      if (high_bandwidth_mode && !bus_width_select) begin
        word_a[11] = data_enable_encoding ? de_lo : serial_bits[11];
        word_a[12] = h_lo;
        word_a[13] = v_lo;
      end else if (sync_encoding_enable) begin
        word_a[11] = (data_enable_encoding && sync_source_select == 2'd1) ? serial_bits[13] : serial_bits[11];
        word_a[12] = h_lo;
        word_a[13] = v_lo;
      end else if (sync_source_select == 2'd2) begin
        word_a[13:11] = serial_bits[13:11];
      end else begin
        word_a[11] = data_enable_encoding ? serial_bits[13] : serial_bits[11];
        word_a[12] = serial_bits[14];
        word_a[13] = serial_bits[15];
      end
    end else if (high_bandwidth_mode) begin
      word_a[12] = h_lo;
      word_a[13] = v_lo;
      word_b[12] = h_hi;
      word_b[13] = v_hi;
      if (pixel_error_check) begin
        for (int i = 0; i < 9; i++) begin
          word_a[i] = serial_bits[i];
          word_b[i] = serial_bits[9 + i];
        end
      end else begin
        word_a[11:0] = serial_bits[11:0];
        word_b[8:0] = serial_bits[20:12];
        word_b[11:9] = serial_bits[26:24];
      end
      if (data_enable_encoding) begin
        word_a[11] = de_lo;
        word_b[11] = de_hi;
      end
    end else if (!sync_encoding_enable) begin
      // Width and second-word offset per bus width and error check
      if (bus_width_select) begin
        n = pixel_error_check ? 12 : 14;
        off = pixel_error_check ? 12 : 15;
      end else begin
        n = pixel_error_check ? 8 : 11;
        off = n;
      end
      for (int i = 0; i < 14; i++) begin
        if (i < n) begin
          word_a[i] = serial_bits[i];
          word_b[i] = serial_bits[off + i];
        end
      end
    end else begin
      word_a[12] = h_lo;
      word_a[13] = v_lo;
      word_b[12] = h_hi;
      word_b[13] = v_hi;
      if (!bus_width_select) begin
        n = pixel_error_check ? 8 : 11;
        for (int i = 0; i < 11; i++) begin
          if (i < n) begin
            word_a[i] = serial_bits[i];
            word_b[i] = serial_bits[n + i];
          end
        end
        // Data enable moves the top data bit up to output 11
        if (data_enable_encoding) begin
          word_a[n - 1] = 1'b0;
          word_a[11] = serial_bits[n - 1];
          word_b[n - 1] = 1'b0;
          word_b[11] = serial_bits[2 * n - 1];
        end
      end else if (pixel_error_check) begin
        word_a[11:0] = serial_bits[11:0];
        word_b[11:0] = serial_bits[23:12];
      end else begin
        word_a[10:0] = serial_bits[10:0];
        word_b[10:0] = serial_bits[25:15];
        word_a[11] = (data_enable_encoding && sync_source_select == 2'd1) ? serial_bits[13] : serial_bits[11];
        word_b[11] = (data_enable_encoding && sync_source_select == 2'd1) ? serial_bits[28] : serial_bits[26];
      end
    end
  end

endmodule

// ### logic/pair_buffer.sv
/*
  Two-entry buffer between the word sequencer and the video sink.
  Assumes a single clock; ready and valid follow the usual handshake.
*/
`timescale 1ns/1ns
module pair_buffer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire xbar_pkg::out_word_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output xbar_pkg::out_word_t out_data
);
  xbar_pkg::out_word_t mem_reg [2];
  xbar_pkg::out_word_t mem_next [2];
  logic wr_ptr_reg;
  logic wr_ptr_next;
  logic rd_ptr_reg;
  logic rd_ptr_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic push;
  logic pop;

  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'd1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule

// ### testbench/video_sink.sv
/*
  Video sink model: collects output words, stalls on request.
  Assumes the ready/valid handshake of the output stage on pclk.
*/
`timescale 1ns/1ns
module video_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic pix_valid,
  input wire logic [13:0] dout,
  input wire logic horizontal_sync,
  input wire logic vertical_sync,
  input wire logic data_valid_flag,
  output logic pix_ready
);
  // ****
  // Handshake
  // ****
  xbar_pkg::out_word_t q[$];
  // Never ready in reset, so no word is taken before the stage is live
  assign pix_ready = presetn && !stall;
  always @(posedge pclk) begin
    if (presetn && pix_valid && pix_ready) begin
      q.push_back({data_valid_flag, vertical_sync, horizontal_sync, dout});
    end
  end
endmodule

// ### testbench/xbar_checker_assertions.sv
/*
  Port-level checks of the parallel output stage.
  Assumes one pclk domain and the layout in xbar_regs.svh.
*/
`timescale 1ns/1ns
`include "xbar_regs.svh"
module xbar_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_clk,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [13:0] dout,
  input wire logic horizontal_sync,
  input wire logic vertical_sync,
  input wire logic data_valid_flag
);
  // ****
  // Helpers
  // ****
  logic lo_wr;
  logic hi_wr;
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_wr <= 1'b0;
      hi_wr <= 1'b0;
    end else if (psel && penable && pwrite) begin
      lo_wr <= lo_wr || (paddr == `XBAR_LO_ADDR);
      hi_wr <= hi_wr || (paddr == `XBAR_HI_ADDR);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable; endsequence
  sequence s_link_rise; $rose(link_clk) ##0 !pix_valid; endsequence
  sequence s_stall; pix_valid && !pix_ready; endsequence
  // ****
  // Properties
  // ****
  property p_ready; s_access |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_unmapped; s_access ##0 (paddr > `STATUS_ADDR) |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; s_access ##0 (paddr <= `STATUS_ADDR && paddr[1:0] == 2'b00) |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_idle_rd; !rd_acc |-> prdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("prdata not zero outside read");
  property p_hold; s_stall |=> pix_valid && $stable(dout) && $stable({horizontal_sync, vertical_sync}); endproperty
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  property p_push; s_link_rise |-> ##[2:8] pix_valid; endproperty
  a_push: assert property (p_push) else $error("no word after link edge");
  property p_lo_rst; s_access ##0 (!pwrite && paddr == `XBAR_LO_ADDR && !lo_wr) |-> prdata == `XBAR_LO_RESET;
  endproperty
  a_lo_rst: assert property (p_lo_rst) else $error("low crossbar reset value wrong");
  property p_hi_rst; s_access ##0 (!pwrite && paddr == `XBAR_HI_ADDR && !hi_wr) |-> prdata == {8'h00, `XBAR_HI_RESET};
  endproperty
  a_hi_rst: assert property (p_hi_rst) else $error("high crossbar reset value wrong");
endmodule
bind parallel_output_width_crossbar xbar_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .dout(dout), .horizontal_sync(horizontal_sync),
  .vertical_sync(vertical_sync), .data_valid_flag(data_valid_flag));

// ### testbench/tb.sv
/*
  Self-checking bench of the parallel output stage.
  Assumes the design, the video sink model and the bound checker.
*/
`timescale 1ns/1ns
`include "xbar_regs.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic link_clk = 1'b0;
  logic [28:0] serial_bits = 29'h0;
  logic [2:0] lo = 3'b000;
  logic [2:0] hi = 3'b000;
  logic stall = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pix_valid;
  logic pix_ready;
  logic [13:0] dout;
  logic horizontal_sync;
  logic vertical_sync;
  logic data_valid_flag;
  logic [31:0] rd;
  logic last_err;
  logic [28:0] pat = 29'h1a5f3c96;
  logic [7:0] cfgs [10] = '{8'h80, 8'h04, 8'h90, 8'h03, 8'h02, 8'h0a, 8'h0b, 8'h1b, 8'h0e, 8'h81};
  int wid [10] = '{14, 12, 12, 14, 11, 8, 12, 12, 9, 14};
  int hb [10] = '{0, 0, 0, 15, 11, 8, 12, 12, 9, 0};
  logic [1:0] src [10] = '{2'd2, 2'd0, 2'd2, 2'd3, 2'd3, 2'd3, 2'd3, 2'd1, 2'd0, 2'd2};
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  always #10 pclk = ~pclk;
  parallel_output_width_crossbar DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .serial_bits(serial_bits), .h_lo(lo[0]), .v_lo(lo[1]), .de_lo(lo[2]), .h_hi(hi[0]),
    .v_hi(hi[1]), .de_hi(hi[2]), .pix_valid(pix_valid), .pix_ready(pix_ready), .dout(dout),
    .horizontal_sync(horizontal_sync), .vertical_sync(vertical_sync), .data_valid_flag(data_valid_flag));
  video_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall), .pix_valid(pix_valid), .dout(dout),
    .horizontal_sync(horizontal_sync), .vertical_sync(vertical_sync), .data_valid_flag(data_valid_flag),
    .pix_ready(pix_ready));
  // ****
  // Tasks
  // ****
  task automatic final_report();
    $display("Comparisons %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: register %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input xbar_pkg::out_word_t got, input xbar_pkg::out_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One link period of 160 ns; data held for the whole period
  task automatic send(input logic [28:0] b, input logic [2:0] l, input logic [2:0] h);
    serial_bits <= b;
    lo <= l;
    hi <= h;
    link_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    link_clk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic take(input xbar_pkg::out_word_t exp);
    int n;
    n = 0;
    while (sink.q.size() == 0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (sink.q.size() == 0) chk_reg(32'h0, 32'h1);
    else chk_word(sink.q.pop_front(), exp);
  endtask
  function automatic xbar_pkg::out_word_t exp_word(input logic [28:0] b, input logic [2:0] s, input int base,
    input int w, input logic hv);
    logic [28:0] m;
    m = (b >> base) & ((29'h1 << w) - 29'h1);
    if (hv) m = {15'h0, s[1:0], m[11:0]};
    return {s, m[13:0]};
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CFG_ADDR, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b1, 12'h010, 32'hffffffff);
    chk_reg({31'h0, last_err}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk_reg(rd, 32'h0);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, `CFG_ADDR, {24'h0, cfgs[i]});
      apb(1'b0, `STATUS_ADDR, 32'h0);
      chk_reg(rd & 32'h3, {30'h0, src[i]});
      send(pat ^ 29'(i), 3'b101, 3'b010);
      take(exp_word(pat ^ 29'(i), 3'b101, 0, wid[i], cfgs[i][2] || cfgs[i][4]));
      if (cfgs[i][1]) take(exp_word(pat ^ 29'(i), 3'b010, hb[i], wid[i], cfgs[i][2] || cfgs[i][4]));
    end
    apb(1'b1, `CFG_ADDR, 32'h80);
    apb(1'b0, `XBAR_LO_ADDR, 32'h0);
    chk_reg(rd, `XBAR_LO_RESET);
    apb(1'b0, `XBAR_HI_ADDR, 32'h0);
    chk_reg(rd, {8'h00, `XBAR_HI_RESET});
    apb(1'b1, `XBAR_LO_ADDR, 32'h765444fe);
    apb(1'b1, `XBAR_HI_ADDR, 32'hffdcba98);
    apb(1'b0, `XBAR_HI_ADDR, 32'h0);
    chk_reg(rd, 32'h00dcba98);
    send(pat, 3'b000, 3'b111);
    take({3'b000, pat[13:4], pat[4], pat[4], 2'b10});
    apb(1'b1, `XBAR_LO_ADDR, 32'h76543210);
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) send(pat + 29'(i), 3'b001, 3'b000);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk_reg(rd & 32'h0000ff04, 32'h00000704);
    stall <= 1'b0;
    take({3'b001, pat[13:0]});
    take({3'b001, pat[13:0] + 14'h1});
    take({3'b001, pat[13:0] + 14'h2});
    repeat (20) @(posedge pclk);
    chk_reg(32'(sink.q.size()), 32'h0);
    apb(1'b1, `STATUS_ADDR, 32'h4);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk_reg(rd & 32'h4, 32'h0);
    final_report();
  end
endmodule
